// >>> core/lps_consts.svh
// Constants for the pixel serializer and palette: codes, field positions, sizes.
// Assumes inclusion by bare name from the package and from each design module.
`ifndef LPS_CONSTS_SVH
`define LPS_CONSTS_SVH

`define LPS_PW_1 3'h0
`define LPS_PW_2 3'h1
`define LPS_PW_4 3'h2
`define LPS_PW_8 3'h3
`define LPS_PW_16 3'h4
`define LPS_PW_24 3'h5

`define LPS_DT_STN_MONO 2'h0
`define LPS_DT_STN_COLOR 2'h1
`define LPS_DT_TFT 2'h2

`define LPS_ORDER_LITTLE 1'b0
`define LPS_ORDER_BIG 1'b1

`define LPS_RED_LSB 0
`define LPS_GREEN_LSB 5
`define LPS_BLUE_LSB 10
`define LPS_INTENSITY_BIT 15

`define LPS_LUT_ENTRIES 256
`define LPS_LUT_WIDTH 16
`define LPS_WORD_WIDTH 32
`define LPS_FIFO_DEPTH 32
`define LPS_MAX_PIX 24

`define LPS_BITS_RESET 64'h0000_0000_0000_0000
`define LPS_CNT_RESET 7'h00
`define LPS_PIX_RESET 24'h00_0000
`define LPS_ENTRY_RESET 16'h0000
`define LPS_HOST_RESET 32'h0000_0000

`endif

// >>> core/lps_pkg.sv
// Types shared by the pixel serializer and palette block.
// Assumes lps_consts.svh is on the include path.
`include "lps_consts.svh"

package lps_pkg;

	typedef enum logic [2:0] {
		LPS_PW1 = `LPS_PW_1,
		LPS_PW2 = `LPS_PW_2,
		LPS_PW4 = `LPS_PW_4,
		LPS_PW8 = `LPS_PW_8,
		LPS_PW16 = `LPS_PW_16,
		LPS_PW24 = `LPS_PW_24
	} lps_pwidth_e;

	typedef enum logic [1:0] {
		LPS_STN_MONO = `LPS_DT_STN_MONO,
		LPS_STN_COLOR = `LPS_DT_STN_COLOR,
		LPS_TFT = `LPS_DT_TFT
	} lps_dtype_e;

	typedef logic [`LPS_LUT_WIDTH-1:0] lps_entry_t;

endpackage : lps_pkg

// >>> core/lps_fifo.sv
// Word FIFO in front of the serializer, flip-flop storage.
// Assumes one clock; both ready and valid come straight from flip-flops.
`timescale 1ns/100ps
`default_nettype none

`include "lps_consts.svh"

module lps_fifo #(
	parameter int WIDTH = `LPS_WORD_WIDTH,
	parameter int DEPTH = `LPS_FIFO_DEPTH
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic wr_valid,
	output logic wr_ready,
	output logic [WIDTH-1:0] rd_data,
	output logic rd_valid,
	input wire logic rd_ready
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	generate
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
			$error("lps_fifo: DEPTH must be a power of two of at least 2");
		end
	endgenerate

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0] count_reg;
	logic [AW:0] count_next;
	logic push;
	logic pop;

	assign push = wr_valid && wr_ready;
	assign pop = rd_valid && rd_ready;
	assign rd_data = mem[rd_ptr_reg];

	always_comb begin
		count_next = count_reg;
		if (push && !pop) begin
			count_next = count_reg + (AW+1)'(1);
		end else if (pop && !push) begin
			count_next = count_reg - (AW+1)'(1);
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
			wr_ready <= 1'b0;
			rd_valid <= 1'b0;
		end else begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + AW'(1);
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + AW'(1);
			end
			count_reg <= count_next;
			wr_ready <= (count_next != (AW+1)'(DEPTH));
			rd_valid <= (count_next != '0);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem[wr_ptr_reg] <= wr_data;
		end
	end

endmodule : lps_fifo

`default_nettype wire

// >>> core/lps_lut.sv
// Palette lookup table of 256 entries of 16 bits, with a host port.
// Assumes host accesses are single-cycle strobes on the core clock.
`timescale 1ns/100ps
`default_nettype none

`include "lps_consts.svh"

module lps_lut (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic [7:0] pix_index,
	output lps_pkg::lps_entry_t pix_entry,
	input wire logic host_wr_en,
	input wire logic host_rd_en,
	input wire logic [7:0] host_addr,
	input wire logic [31:0] host_wdata,
	output logic [31:0] host_rdata,
	output logic host_rd_valid
);
	import lps_pkg::*;

	lps_entry_t mem [`LPS_LUT_ENTRIES];

	assign pix_entry = mem[pix_index];

	// R8 - free 16-bit entries.
	generate
		for (genvar i = 0; i < `LPS_LUT_ENTRIES; i++) begin : g_entry
			always_ff @(posedge ref_clk or negedge reset_n) begin
				if (!reset_n) begin
					mem[i] <= `LPS_ENTRY_RESET;
				end else if (host_wr_en && host_addr == 8'(i)) begin
					// R7 - upper half ignored.
					mem[i] <= host_wdata[15:0];
				end
			end
		end
	endgenerate

	// R7 - half-word readback.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			host_rdata <= `LPS_HOST_RESET;
			host_rd_valid <= 1'b0;
		end else begin
			host_rd_valid <= host_rd_en;
			if (host_rd_en) begin
				host_rdata <= {16'h0000, mem[host_addr]};
			end
		end
	end

endmodule : lps_lut

`default_nettype wire

// >>> core/lps_serpal.sv
// Pixel serializer and palette stage of the display datapath.
// Assumes configuration ports are static while a stream runs and come from core-clock logic.
//
// Operation
// R1 - Unpack 32-bit FIFO words into pixels of 1, 2, 4, 8, 16 or 24 bits.
// R2 - Support big-endian and little-endian pixel order, chosen by byte order select.
// R3 - Little-endian: first pixel from least significant bits of the word.
// R4 - Big-endian: first pixel from most significant bits of the word.
// R5 - Palettized pixel value indexes the lookup table; output its colour or gray.
// R6 - Palette used per display type and width; bypassed for the other widths.
// R7 - Host reads/writes entries as half-words by word access; upper bits ignored.
// R8 - Table holds 256 entries of 16 bits, each freely programmable.
// R9 - Entry layout: red 4:0, green 9:5, blue 14:10, intensity 15.
// R10 - STN mono uses upper four red bits only: 16 gray shades.
// R11 - STN colour uses upper four bits of each component: 4096 colours.
// R12 - TFT uses all five bits of each component: 32768 colours.
// R13 - TFT palettized: intensity bit drives output bits 18, 10 and 2.
// R14 - TFT palettized: output bits 17:16, 9:8 and 1:0 held low.
// R15 - 24-bit pixels pack contiguously, carrying split bits into the next word.
// R16 - Non-palettized pixels pass through with no table access.
`timescale 1ns/100ps
`default_nettype none

`include "lps_consts.svh"

module lps_serpal #(
	parameter int FIFO_DEPTH = `LPS_FIFO_DEPTH
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic [31:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic serializer_flush,
	input wire lps_pkg::lps_pwidth_e pixel_width_select,
	input wire lps_pkg::lps_dtype_e display_type_select,
	input wire logic memory_byte_order,
	input wire logic lut_wr_en,
	input wire logic lut_rd_en,
	input wire logic [7:0] lut_addr,
	input wire logic [31:0] lut_wdata,
	output logic [31:0] lut_rdata,
	output logic lut_rd_valid,
	output logic [23:0] panel_data_bus,
	output logic pix_valid,
	input wire logic pix_ready,
	output logic pix_palettized
);
	import lps_pkg::*;

	// A depth that is not a power of two would break the FIFO's wrapping pointers.
	generate
		if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_bad
			$error("lps_serpal: FIFO_DEPTH must be a power of two of at least 2");
		end
	endgenerate

	// ------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------

	// R1 - width from select.
	function automatic logic [4:0] pix_bits(input lps_pwidth_e code);
		logic [4:0] w;
		w = 5'h01;
		case (code)
			LPS_PW1: begin
				w = 5'h01;
			end
			LPS_PW2: begin
				w = 5'h02;
			end
			LPS_PW4: begin
				w = 5'h04;
			end
			LPS_PW8: begin
				w = 5'h08;
			end
			LPS_PW16: begin
				w = 5'h10;
			end
			LPS_PW24: begin
				w = 5'h18;
			end
			default: begin
				w = 5'h01;
			end
		endcase
		return w;
	endfunction : pix_bits

	// R6 - palette selection.
	function automatic logic uses_palette(input lps_dtype_e dt, input logic [4:0] w);
		logic pal;
		pal = 1'b0;
		case (dt)
			LPS_TFT: begin
				pal = (w <= 5'h08);
			end
			LPS_STN_MONO: begin
				pal = (w <= 5'h02);
			end
			LPS_STN_COLOR: begin
				pal = (w <= 5'h08);
			end
			default: begin
				pal = 1'b0;
			end
		endcase
		return pal;
	endfunction : uses_palette

	// ------------------------------------------------------------
	// Panel word formatting
	// ------------------------------------------------------------

	// Small helpers keep the lane layout in one place for all three components.
	// R13 - intensity as lane bit 2.
	function automatic logic [7:0] tft_lane(input logic [4:0] comp, input logic ibit);
		logic [7:0] lane;
		// R14 - padding bits low.
		lane = {comp, ibit, 2'b00};
		return lane;
	endfunction : tft_lane

	// R11 - upper four bits.
	function automatic logic [3:0] stn_nibble(input logic [4:0] comp);
		logic [3:0] nib;
		nib = comp[4:1];
		return nib;
	endfunction : stn_nibble

	// ------------------------------------------------------------
	// Input FIFO
	// ------------------------------------------------------------

	logic [31:0] word_data;
	logic word_valid;
	logic word_take;

	lps_fifo #(
		.WIDTH(`LPS_WORD_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.wr_data(in_data),
		.wr_valid(in_valid),
		.wr_ready(in_ready),
		.rd_data(word_data),
		.rd_valid(word_valid),
		.rd_ready(word_take)
	);

	// ------------------------------------------------------------
	// Serializer bit buffer
	// ------------------------------------------------------------

	// Little-endian keeps valid bits at the bottom, big-endian at the top,
	// so the next pixel always sits at a fixed end of the buffer.
	logic [63:0] bits_reg;
	logic [63:0] bits_next;
	logic [6:0] cnt_reg;
	logic [4:0] width;
	logic [6:0] width7;
	logic have_pix;
	logic out_free;
	logic emit;
	logic [23:0] raw_pix;
	logic [23:0] pix_mask;
	logic [63:0] word_wide;

	assign width = pix_bits(pixel_width_select);
	assign width7 = {2'b00, width};
	assign have_pix = (cnt_reg >= width7);
	assign out_free = !pix_valid || pix_ready;
	assign emit = have_pix && out_free && !serializer_flush;
	// A word is fetched only when the buffer cannot yield a pixel, which
	// bounds the fill at 55 bits and trades a little throughput for size.
	assign word_take = !have_pix && word_valid && !serializer_flush;
	assign word_wide = {32'h0000_0000, word_data};
	// A 25-bit intermediate keeps the 24-bit mask from overflowing.
	assign pix_mask = 24'((25'h000_0001 << width) - 25'h000_0001);

	always_comb begin
		raw_pix = `LPS_PIX_RESET;
		if (memory_byte_order == `LPS_ORDER_LITTLE) begin
			// R3 - first pixel low.
			raw_pix = bits_reg[23:0] & pix_mask;
		end else begin
			// R4 - first pixel high.
			raw_pix = 24'(bits_reg[63:40] >> (5'h18 - width));
		end
	end

	// R15 - carry split pixels.
	// Both shifts fill with zeros, so bits beyond the fill level stay clear for the merge.
	always_comb begin
		bits_next = bits_reg;
		if (serializer_flush) begin
			bits_next = `LPS_BITS_RESET;
		end else if (emit) begin
			// R2 - order-dependent consume.
			if (memory_byte_order == `LPS_ORDER_LITTLE) begin
				bits_next = bits_reg >> width;
			end else begin
				bits_next = bits_reg << width;
			end
		end else if (word_take) begin
			// R1 - append fetched word.
			if (memory_byte_order == `LPS_ORDER_LITTLE) begin
				bits_next = bits_reg | (word_wide << cnt_reg);
			end else begin
				bits_next = bits_reg | (word_wide << (7'h20 - cnt_reg));
			end
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			bits_reg <= `LPS_BITS_RESET;
		end else begin
			bits_reg <= bits_next;
		end
	end

	// R1 - buffer fill level.
	// At most 55 bits are ever held, so seven count bits suffice.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_reg <= `LPS_CNT_RESET;
		end else if (serializer_flush) begin
			cnt_reg <= `LPS_CNT_RESET;
		end else if (emit) begin
			cnt_reg <= cnt_reg - width7;
		end else if (word_take) begin
			cnt_reg <= cnt_reg + 7'h20;
		end
	end

	// ------------------------------------------------------------
	// Palette
	// ------------------------------------------------------------

	lps_entry_t entry;
	logic palettized;
	logic [4:0] red;
	logic [4:0] green;
	logic [4:0] blue;
	logic inten;
	logic [23:0] formatted;
	logic [7:0] lut_index;

	lps_lut u_lut (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.pix_index(lut_index),
		.pix_entry(entry),
		.host_wr_en(lut_wr_en),
		.host_rd_en(lut_rd_en),
		.host_addr(lut_addr),
		.host_wdata(lut_wdata),
		.host_rdata(lut_rdata),
		.host_rd_valid(lut_rd_valid)
	);

	// R5 - pixel value as index.
	// Wide pixels still present an index; their entry is simply not used.
	assign lut_index = raw_pix[7:0];

	assign palettized = uses_palette(display_type_select, width);

	// R9 - entry fields.
	assign red = entry[`LPS_RED_LSB +: 5];
	assign green = entry[`LPS_GREEN_LSB +: 5];
	assign blue = entry[`LPS_BLUE_LSB +: 5];
	assign inten = entry[`LPS_INTENSITY_BIT];

	always_comb begin
		formatted = raw_pix;
		if (!palettized) begin
			// R16 - raw pass-through.
			formatted = raw_pix;
		end else begin
			// R5 - index the table.
			case (display_type_select)
				LPS_TFT: begin
					// R12 - all five bits.
					formatted = {tft_lane(blue, inten), tft_lane(green, inten),
						tft_lane(red, inten)};
				end
				LPS_STN_MONO: begin
					// R10 - upper red bits.
					formatted = {20'h0_0000, stn_nibble(red)};
				end
				LPS_STN_COLOR: begin
					// R11 - upper four bits each.
					formatted = {12'h000, stn_nibble(blue), stn_nibble(green), stn_nibble(red)};
				end
				default: begin
					formatted = raw_pix;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Output register
	// ------------------------------------------------------------

	// The next stage may stall; the buffer then holds and the FIFO fills,
	// so back-pressure reaches the word source through in_ready.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			pix_valid <= 1'b0;
		end else if (serializer_flush) begin
			pix_valid <= 1'b0;
		end else if (out_free) begin
			pix_valid <= emit;
		end
	end

	// R5 - colour to panel.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			panel_data_bus <= `LPS_PIX_RESET;
		end else if (emit) begin
			panel_data_bus <= formatted;
		end
	end

	// R6 - palette use flag.
	// Later stages read this to tell table colours from raw pixels.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			pix_palettized <= 1'b0;
		end else if (emit) begin
			pix_palettized <= palettized;
		end
	end

endmodule : lps_serpal

`default_nettype wire

// >>> verification/lps_serpal_chk.sv
// Concurrent checks on the ports of the pixel serializer and palette.
// Assumes it is bound into lps_serpal and sees nothing but its ports.
`timescale 1ns/100ps
`default_nettype none

module lps_serpal_chk (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire lps_pkg::lps_pwidth_e pixel_width_select,
	input wire lps_pkg::lps_dtype_e display_type_select,
	input wire logic serializer_flush,
	input wire logic lut_rd_en,
	input wire logic [31:0] lut_rdata,
	input wire logic lut_rd_valid,
	input wire logic [23:0] panel_data_bus,
	input wire logic pix_valid,
	input wire logic pix_ready,
	input wire logic pix_palettized
);
	import lps_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	logic pal_exp;
	logic pal_out;
	assign pal_exp = (display_type_select == LPS_STN_MONO) ? (pixel_width_select <= LPS_PW2)
		: (display_type_select != 2'h3) && (pixel_width_select <= LPS_PW8);
	assign pal_out = pix_valid && pix_palettized;
	sequence s_read;
		lut_rd_en ##1 lut_rd_valid;
	endsequence
	a_read_answer: assert property (lut_rd_en |-> s_read)
		else $error("table read not answered next cycle");
	a_read_cause: assert property (lut_rd_valid |-> $past(lut_rd_en))
		else $error("table read answer without request");
	a_upper_zero: assert property (lut_rd_valid |-> lut_rdata[31:16] == 16'h0000)
		else $error("table read upper half not zero");
	a_pal_select: assert property (pix_valid && pixel_width_select <= LPS_PW24 |-> pix_palettized == pal_exp)
		else $error("palette use does not match mode");
	a_tft_intensity: assert property (pal_out && display_type_select == LPS_TFT
		|-> panel_data_bus[18] == panel_data_bus[10] && panel_data_bus[10] == panel_data_bus[2])
		else $error("intensity bits differ");
	a_tft_zero: assert property (pal_out && display_type_select == LPS_TFT
		|-> {panel_data_bus[17:16], panel_data_bus[9:8], panel_data_bus[1:0]} == 6'h00)
		else $error("unused panel bits not low");
	a_mono_gray: assert property (pal_out && display_type_select == LPS_STN_MONO
		|-> panel_data_bus[23:4] == 20'h0_0000)
		else $error("gray output wider than four bits");
	a_colour_width: assert property (pal_out && display_type_select == LPS_STN_COLOR
		|-> panel_data_bus[23:12] == 12'h000)
		else $error("colour output wider than twelve bits");
	a_pix_hold: assert property (pix_valid && !pix_ready && !serializer_flush
		|=> pix_valid && $stable(panel_data_bus))
		else $error("pixel changed while stalled");
endmodule : lps_serpal_chk

bind lps_serpal lps_serpal_chk u_chk (.ref_clk, .reset_n, .pixel_width_select,
	.display_type_select, .serializer_flush, .lut_rd_en, .lut_rdata, .lut_rd_valid,
	.panel_data_bus, .pix_valid, .pix_ready, .pix_palettized);

`default_nettype wire

// >>> verification/lps_panel_model.sv
// Panel side of the pixel output: accepts pixels, pausing when told to.
// Assumes the core clock; mode 0 always ready, 1 random stalls, 2 holds off.
`timescale 1ns/100ps
`default_nettype none

module lps_panel_model (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic [1:0] stall_mode,
	output logic pix_ready
);
	// Random pauses make the stall path see traffic, not only the easy case.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			pix_ready <= 1'b0;
		end else begin
			pix_ready <= (stall_mode == 2'h0) || (stall_mode == 2'h1 && $urandom_range(1) == 1);
		end
	end
endmodule : lps_panel_model

`default_nettype wire

// >>> verification/tb.sv
// Self-checking bench for the pixel serializer and palette.
// Assumes lps_pkg, the design modules, the checker and the panel model are compiled first.
`timescale 1ns/100ps
`default_nettype none

module tb;
	import lps_pkg::*;
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic [31:0] in_data = 32'h0000_0000;
	logic in_valid = 1'b0;
	logic in_ready;
	logic serializer_flush = 1'b0;
	lps_pwidth_e pixel_width_select = LPS_PW1;
	lps_dtype_e display_type_select = LPS_TFT;
	logic memory_byte_order = 1'b0;
	logic lut_wr_en = 1'b0;
	logic lut_rd_en = 1'b0;
	logic [7:0] lut_addr = 8'h00;
	logic [31:0] lut_wdata = 32'h0000_0000;
	logic [31:0] lut_rdata;
	logic lut_rd_valid;
	logic [23:0] panel_data_bus;
	logic pix_valid;
	logic pix_ready;
	logic pix_palettized;
	logic [1:0] stall_mode = 2'h0;
	int failures = 0;
	int check_count = 0;
	int refused = 0;
	int wid [6] = '{1, 2, 4, 8, 16, 24};
	logic [15:0] lut_mem [256];
	logic [23:0] pix_q [$];
	logic [31:0] rd_q [$];

	always #5 ref_clk = ~ref_clk;

	lps_serpal uut (.ref_clk, .reset_n, .in_data, .in_valid, .in_ready, .serializer_flush,
		.pixel_width_select, .display_type_select, .memory_byte_order, .lut_wr_en, .lut_rd_en,
		.lut_addr, .lut_wdata, .lut_rdata, .lut_rd_valid, .panel_data_bus, .pix_valid,
		.pix_ready, .pix_palettized);
	lps_panel_model u_panel (.ref_clk, .reset_n, .stall_mode, .pix_ready);

	task automatic report(string what, logic [31:0] exp, logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : report

	task automatic chk_pix(logic [23:0] exp, logic [23:0] got);
		report("pixel", {8'h00, exp}, {8'h00, got});
	endtask : chk_pix

	task automatic chk_rd(logic [31:0] exp, logic [31:0] got);
		report("table read", exp, got);
	endtask : chk_rd

	task automatic end_of_test();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : end_of_test

	task automatic timed_out();
		report("wait", 32'h0000_0001, 32'h0000_0000);
		end_of_test();
	endtask : timed_out

	always @(posedge ref_clk) begin
		if (reset_n && pix_valid === 1'b1 && pix_ready === 1'b1) begin
			if (pix_q.size() == 0) report("pixel count", 32'h0000_0000, 32'h0000_0001);
			else chk_pix(pix_q.pop_front(), panel_data_bus);
		end
		if (reset_n && lut_rd_valid === 1'b1) begin
			if (rd_q.size() == 0) report("read count", 32'h0000_0000, 32'h0000_0001);
			else chk_rd(rd_q.pop_front(), lut_rdata);
		end
	end

	// Expected panel word: table entry for palettized modes, raw pixel otherwise.
	function automatic logic [23:0] fmt(logic [23:0] p);
		logic [15:0] e;
		e = lut_mem[p[7:0]];
		if (display_type_select == LPS_STN_MONO ? pixel_width_select > LPS_PW2
			: pixel_width_select > LPS_PW8) return p;
		case (display_type_select)
			LPS_TFT: return {e[14:10], e[15], 2'h0, e[9:5], e[15], 2'h0, e[4:0], e[15], 2'h0};
			LPS_STN_MONO: return {20'h0_0000, e[4:1]};
			default: return {12'h000, e[14:11], e[9:6], e[4:1]};
		endcase
	endfunction : fmt

	task automatic lut_read(logic [7:0] a);
		rd_q.push_back({16'h0000, lut_mem[a]});
		lut_addr <= a;
		lut_rd_en <= 1'b1;
		@(posedge ref_clk);
		lut_rd_en <= 1'b0;
		@(posedge ref_clk);
	endtask : lut_read

	task automatic push(logic [31:0] w);
		int n;
		n = 0;
		in_data <= w;
		in_valid <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
			if (in_ready !== 1'b1) refused++;
		end while (in_ready !== 1'b1 && n < 600);
		if (n >= 600) timed_out();
	endtask : push

	task automatic run_test(int dt, int pw, int ord, int groups, bit hold);
		logic [31:0] wd [3];
		logic [95:0] s;
		int w;
		int n;
		w = wid[pw];
		serializer_flush <= 1'b1;
		@(posedge ref_clk);
		display_type_select <= lps_dtype_e'(dt);
		pixel_width_select <= lps_pwidth_e'(pw);
		memory_byte_order <= ord[0];
		stall_mode <= hold ? 2'h2 : 2'($urandom_range(1));
		@(posedge ref_clk);
		serializer_flush <= 1'b0;
		if (hold) fork begin
			repeat (300) @(posedge ref_clk);
			stall_mode <= 2'h1;
		end join_none
		for (int g = 0; g < groups; g++) begin
			foreach (wd[k]) wd[k] = $urandom;
			s = ord ? {wd[0], wd[1], wd[2]} : {wd[2], wd[1], wd[0]};
			for (int i = 0; i < 96 / w; i++)
				pix_q.push_back(fmt(ord ? 24'((s << (i * w)) >> (96 - w)) : 24'((s >> (i * w)) & ((96'h1 << w) - 1))));
			foreach (wd[k]) push(wd[k]);
		end
		in_valid <= 1'b0;
		n = 0;
		while (pix_q.size() > 0 && n < 3000) begin
			@(posedge ref_clk);
			n++;
		end
		if (n >= 3000) timed_out();
		$display("test type %0d width %0d order %0d done", dt, w, ord);
	endtask : run_test

	initial begin
		void'($urandom(32'hd18f0267));
		foreach (lut_mem[i]) lut_mem[i] = 16'h0000;
		repeat (10) @(posedge ref_clk);
		reset_n <= 1'b1;
		@(posedge ref_clk);
		lut_read(8'hff);
		for (int i = 0; i < 256; i++) begin
			lut_addr <= 8'(i);
			lut_wdata <= $urandom;
			lut_wr_en <= 1'b1;
			@(posedge ref_clk);
			lut_mem[i] = lut_wdata[15:0];
		end
		lut_wr_en <= 1'b0;
		for (int i = 0; i < 8; i++) lut_read(8'($urandom));
		lut_read(8'h00);
		$display("test table access done");
		for (int dt = 0; dt < 3; dt++)
			for (int pw = 0; pw < 6; pw++)
				for (int ord = 0; ord < 2; ord++) run_test(dt, pw, ord, 1, 1'b0);
		run_test(2, 3, 1, 12, 1'b1);
		report("refusals", 32'h0000_0001, {31'h0, refused > 0});
		report("ready when empty", 32'h0000_0001, {31'h0, in_ready});
		report("reads pending", 32'h0000_0000, 32'(rd_q.size()));
		end_of_test();
	end
endmodule : tb

`default_nettype wire
